// >>> pcad_position_counter.sv
// Step/microstep and encoder counters with zero and set-position handling,
// logical target bookkeeping and nonvolatile save of the last position.
// Assumes step, encoder and command strobes come from logic on clk.
`timescale 1ns/10ps

// Notes on behaviour
// R1 - Set-zero clears step and encoder counters.
// R2 - All counters change in one clock edge.
// R3 - Zeroing leaves a running movement untouched.
// R4 - Zeroing shifts logical target by same amount.
// R5 - Zeroing keeps next offset shift destination physical.
// R6 - Set-position loads step and encoder values.
// R7 - Ignore flags leave the matching counter alone.
// R8 - Set-position never forces target to zero.
// R9 - Set-position keeps physical end of motion.
// R10 - Last position saved without any host command.
// R11 - Saved position restored after power-on.
// R12 - Save done within half second after stop.
// R13 - Save during motion marks position approximate.
// R14 - Adjusts land between increments, no edge lost.
module pcad_position_counter #(
  parameter int unsigned QUIET_CYC = pcad_pkg::SAVE_QUIET_CYC,
  parameter int unsigned PER_CYC   = pcad_pkg::SAVE_PER_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    step_pulse,
  input  wire logic                    step_dir,
  input  wire logic                    enc_up,
  input  wire logic                    enc_down,
  input  wire logic                    motion_busy,
  input  wire pcad_pkg::pcad_pos_cmd_t  pos_cmd,
  input  wire pcad_pkg::pcad_move_cmd_t move_cmd,
  input  wire logic                    nv_rd_valid,
  input  wire pcad_pkg::pcad_nv_rec_t   nv_rd_data,
  output pcad_pkg::pcad_pos_t          position,
  output logic signed [pcad_pkg::UPOS_W-1:0] target_pos,
  output logic signed [pcad_pkg::UPOS_W-1:0] shift_dest,
  output logic                         calib_needed,
  output logic                         pos_valid,
  output logic                         nv_rd_req,
  output logic                         nv_wr_en,
  output pcad_pkg::pcad_nv_rec_t       nv_wr_data
);
  import pcad_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic signed [UPOS_W-1:0] upos_q, upos_d;
  logic signed [ENC_W-1:0]  enc_q, enc_d;
  logic signed [UPOS_W-1:0] tgt_q, tgt_d;
  logic signed [UPOS_W-1:0] dest_q, dest_d;
  logic                     calib_q, calib_d;
  logic                     valid_q, valid_d;
  logic signed [UPOS_W-1:0] step_inc;
  logic signed [ENC_W-1:0]  enc_inc;
  logic signed [UPOS_W-1:0] pos_shift;
  logic                     loading;
  logic                     restore;
  logic                     cmd_ok;
  logic                     changed;
  pcad_pos_t                cur_pos;

  // ==========================================================================
  // Increments of this cycle
  // ==========================================================================
  // One microstep per step pulse in the direction given, one count per
  // encoder edge; up and down together cancel.
  always_comb begin
    step_inc = '0;
    if (step_pulse) begin
      step_inc = step_dir ? UPOS_W'(1) : -UPOS_W'(1);
    end
    enc_inc = '0;
    if (enc_up && !enc_down) begin
      enc_inc = ENC_W'(1);
    end else if (enc_down && !enc_up) begin
      enc_inc = -ENC_W'(1);
    end
  end

  // Commands are ignored until the stored record has been restored, since a
  // later restore would otherwise overwrite the host's adjustment.
  assign restore = loading && nv_rd_valid;
  assign cmd_ok  = valid_q;

  // ==========================================================================
  // Counters and targets
  // ==========================================================================
  // The increment of the adjusting cycle is added on top of the new value,
  // so the adjust sits between two counting cycles and no edge vanishes.
  // Target and shift destination move by the same distance as the logical
  // position, which keeps every physical end point where it was.
  always_comb begin
    upos_d    = upos_q + step_inc;
    enc_d     = enc_q + enc_inc;
    tgt_d     = tgt_q;
    dest_d    = dest_q;
    calib_d   = calib_q;
    valid_d   = valid_q;
    pos_shift = '0;
    if (restore) begin
      upos_d  = {nv_rd_data.pos.step, nv_rd_data.pos.ustep};     // R11
      enc_d   = nv_rd_data.pos.enc;
      tgt_d   = {nv_rd_data.pos.step, nv_rd_data.pos.ustep};
      dest_d  = {nv_rd_data.pos.step, nv_rd_data.pos.ustep};
      calib_d = nv_rd_data.moving;                               // R13
      valid_d = 1'b1;
    end else if (cmd_ok && pos_cmd.set_zero) begin
      // Both counters are written in the same edge.
      upos_d    = step_inc;                                      // R1 R2 R14
      enc_d     = enc_inc;                                       // R1 R2 R14
      pos_shift = upos_q;
      tgt_d     = tgt_q - pos_shift;                             // R3 R4
      dest_d    = dest_q - pos_shift;                            // R5
      calib_d   = 1'b0;
    end else if (cmd_ok && pos_cmd.set_position_cmd) begin
      if (!pos_cmd.ign_pos) begin
        upos_d    = pos_cmd.pos + step_inc;                      // R6 R7 R14
        pos_shift = upos_q - pos_cmd.pos;
        tgt_d     = tgt_q - pos_shift;                           // R8 R9
        dest_d    = dest_q - pos_shift;                          // R9
        calib_d   = 1'b0;
      end
      if (!pos_cmd.ign_enc) begin
        enc_d = pos_cmd.enc + enc_inc;                           // R6 R7 R14
      end
    end
    // Target updates from the move logic apply after any adjust of the same
    // cycle, so a relative move counts from the already shifted target.
    if (valid_q) begin
      if (move_cmd.abs_move) begin
        tgt_d = move_cmd.value;
      end else if (move_cmd.relative_move_cmd) begin
        tgt_d = tgt_d + move_cmd.value;
      end
      if (move_cmd.shift_arm) begin
        dest_d = upos_d + move_cmd.value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      upos_q  <= UPOS_RST;
      enc_q   <= ENC_RST;
      tgt_q   <= UPOS_RST;
      dest_q  <= UPOS_RST;
      calib_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      upos_q  <= upos_d;
      enc_q   <= enc_d;
      tgt_q   <= tgt_d;
      dest_q  <= dest_d;
      calib_q <= calib_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================================
  // Nonvolatile save and restore
  // ==========================================================================
  // Anything that moves the counters marks the record as needing a save;
  // the keeper writes it on its own, the host never asks for it.
  assign changed = step_pulse || enc_up || enc_down ||
                   (cmd_ok && (pos_cmd.set_zero ||
                               pos_cmd.set_position_cmd));       // R10

  assign cur_pos = '{step:  upos_q[UPOS_W-1:USTEP_W],
                     ustep: upos_q[USTEP_W-1:0],
                     enc:   enc_q};

  pcad_nv_keeper #(
    .QUIET_CYC (QUIET_CYC),
    .PER_CYC   (PER_CYC)
  ) u_keeper (
    .clk         (clk),
    .rstn        (rstn),
    .motion_busy (motion_busy),
    .changed     (changed),
    .cur_pos     (cur_pos),
    .nv_rd_valid (nv_rd_valid),
    .loading     (loading),
    .nv_rd_req   (nv_rd_req),
    .nv_wr_en    (nv_wr_en),
    .nv_wr_data  (nv_wr_data)
  );                                                             // R10 R12

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // All outputs come from registers, so readers see a consistent pair.
  assign position     = cur_pos;
  assign target_pos   = tgt_q;
  assign shift_dest   = dest_q;
  assign calib_needed = calib_q;
  assign pos_valid    = valid_q;

endmodule

// >>> pcad_pkg.sv
// Shared types and constants for the position counter adjust block.
// Assumes a single 10 MHz system clock and a word-wide nonvolatile store.
package pcad_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int POS_W   = 32;              // Whole steps, signed.
  localparam int USTEP_W = 8;               // Microsteps, 256 per step.
  localparam int ENC_W   = 32;              // Encoder counts, signed.
  localparam int UPOS_W  = POS_W + USTEP_W; // Position in microsteps.
  localparam int TMR_W   = 24;              // Save timer width.

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ         = 10_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  // Latest completion of the save after motion stops.
  localparam int SAVE_LIMIT_MS  = 500;
  localparam int SAVE_LIMIT_CYC = CYC_PER_MS * SAVE_LIMIT_MS;
  // Quiet time after the stop before the final save is written.
  localparam int SAVE_QUIET_MS  = 100;
  localparam int SAVE_QUIET_CYC = CYC_PER_MS * SAVE_QUIET_MS;
  // Spacing of the approximate saves made while the axis moves.
  localparam int SAVE_PER_MS    = 200;
  localparam int SAVE_PER_CYC   = CYC_PER_MS * SAVE_PER_MS;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic signed [UPOS_W-1:0] UPOS_RST = 40'sh00_0000_0000;
  localparam logic signed [ENC_W-1:0]  ENC_RST  = 32'sh0000_0000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Counter pair as seen by the rest of the controller.
  typedef struct packed {
    logic signed [POS_W-1:0] step;
    logic [USTEP_W-1:0]      ustep;
    logic signed [ENC_W-1:0] enc;
  } pcad_pos_t;

  // Position adjust commands, one-cycle strobes with their arguments.
  typedef struct packed {
    logic                     set_zero;
    logic                     set_position_cmd;
    logic                     ign_pos;
    logic                     ign_enc;
    logic signed [UPOS_W-1:0] pos;
    logic signed [ENC_W-1:0]  enc;
  } pcad_pos_cmd_t;

  // Target updates from the movement command logic, one-cycle strobes.
  typedef struct packed {
    logic                     abs_move;
    logic                     relative_move_cmd;
    logic                     shift_arm;
    logic signed [UPOS_W-1:0] value;
  } pcad_move_cmd_t;

  // Record kept in the nonvolatile store.
  typedef struct packed {
    logic      moving;
    pcad_pos_t pos;
  } pcad_nv_rec_t;

  // Save and restore sequencer states.
  typedef enum logic [2:0] {
    NV_RD_REQ,
    NV_RD_WAIT,
    NV_IDLE,
    NV_QUIET
  } pcad_nv_st_t;

endpackage

// >>> pcad_nv_keeper.sv
// Save and restore sequencer for the position record.
// Assumes the store answers a read with nv_rd_valid one clock after nv_rd_req.
`timescale 1ns/10ps
module pcad_nv_keeper #(
  parameter int unsigned QUIET_CYC = pcad_pkg::SAVE_QUIET_CYC,
  parameter int unsigned PER_CYC   = pcad_pkg::SAVE_PER_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  motion_busy,
  input  wire logic                  changed,
  input  wire pcad_pkg::pcad_pos_t   cur_pos,
  input  wire logic                  nv_rd_valid,
  output logic                       loading,
  output logic                       nv_rd_req,
  output logic                       nv_wr_en,
  output pcad_pkg::pcad_nv_rec_t     nv_wr_data
);
  import pcad_pkg::*;

  pcad_nv_st_t         st_q, st_d;
  logic [TMR_W-1:0]    tmr_q, tmr_d;
  logic                dirty_q, dirty_d;
  logic                rd_q, rd_d;
  logic                wr_q, wr_d;
  pcad_nv_rec_t        rec_q, rec_d;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // The quiet timer restarts on every change, so the final save always holds
  // the resting position and finishes well inside the save limit.
  always_comb begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    dirty_d = dirty_q | changed | motion_busy;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    rec_d   = rec_q;
    case (st_q)
      NV_RD_REQ: begin
        rd_d = 1'b1;                                          // R11
        st_d = NV_RD_WAIT;
      end
      NV_RD_WAIT: begin
        dirty_d = 1'b0;
        if (nv_rd_valid) begin
          st_d = NV_IDLE;
        end
      end
      NV_IDLE: begin
        if (motion_busy) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q >= TMR_W'(PER_CYC - 1)) begin
            wr_d  = 1'b1;                                     // R13
            rec_d = '{moving: 1'b1, pos: cur_pos};
            tmr_d = '0;
          end
        end else if (dirty_q) begin
          tmr_d = '0;
          st_d  = NV_QUIET;
        end
      end
      NV_QUIET: begin
        tmr_d = tmr_q + 1'b1;
        if (motion_busy || changed) begin
          tmr_d = '0;
        end else if (tmr_q >= TMR_W'(QUIET_CYC - 1)) begin
          wr_d    = 1'b1;                                     // R10 R12
          rec_d   = '{moving: 1'b0, pos: cur_pos};
          dirty_d = 1'b0;
          tmr_d   = '0;
          st_d    = NV_IDLE;
        end
        if (motion_busy) begin
          st_d = NV_IDLE;
        end
      end
      default: begin
        st_d = NV_RD_REQ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q    <= NV_RD_REQ;
      tmr_q   <= '0;
      dirty_q <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      rec_q   <= '0;
    end else begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      dirty_q <= dirty_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      rec_q   <= rec_d;
    end
  end

  assign loading    = (st_q == NV_RD_WAIT);
  assign nv_rd_req  = rd_q;
  assign nv_wr_en   = wr_q;
  assign nv_wr_data = rec_q;

endmodule

// >>> pcad_nv_model.sv
// Behavioural nonvolatile store that sits beside the position counter.
// Assumes read requests and write strobes arrive as one-cycle pulses.
`timescale 1ns/10ps
module pcad_nv_model
  import pcad_pkg::*;
#(
  parameter pcad_nv_rec_t INIT = '0
) (
  input  wire logic         clk,
  input  wire pcad_nv_rec_t wr_data,
  input  wire logic         rd_req,
  input  wire logic         wr_en,
  output logic              rd_valid,
  output pcad_nv_rec_t      rec,
  output logic              wr_moving,
  output pcad_nv_rec_t      rd_data
);
  // ==========================================================================
  // Store
  // ==========================================================================
  initial begin
    rec = INIT;
    rd_valid = 1'b0;
    wr_moving = 1'b0;
  end
  // Read data is inverted outside the answer so a stale word never passes.
  assign rd_data = rd_valid ? rec : ~rec;
  // The record survives resets of the counter block, as power loss would.
  always @(posedge clk) begin
    rd_valid <= rd_req;
    if (wr_en) begin
      rec <= wr_data;
      if (wr_data.moving) wr_moving <= 1'b1;
    end
  end
endmodule

// >>> pcad_position_counter_chk.sv
// Checker for the position counter's ports.
// Assumes the small save parameters that the bench hands on.
`timescale 1ns/10ps
module pcad_position_counter_chk #(
  parameter int QUIET_CYC = 20
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              step_pulse,
  input  wire logic                              step_dir,
  input  wire logic                              enc_up,
  input  wire logic                              enc_down,
  input  wire logic                              motion_busy,
  input  wire logic                              nv_rd_valid,
  input  wire logic                              calib_needed,
  input  wire logic                              pos_valid,
  input  wire logic                              nv_rd_req,
  input  wire logic                              nv_wr_en,
  input  wire pcad_pkg::pcad_pos_cmd_t           pos_cmd,
  input  wire pcad_pkg::pcad_move_cmd_t          move_cmd,
  input  wire pcad_pkg::pcad_nv_rec_t            nv_rd_data,
  input  wire pcad_pkg::pcad_nv_rec_t            nv_wr_data,
  input  wire pcad_pkg::pcad_pos_t               position,
  input  wire logic signed [pcad_pkg::UPOS_W-1:0] target_pos,
  input  wire logic signed [pcad_pkg::UPOS_W-1:0] shift_dest
);
  import pcad_pkg::*;

  // The final save follows the quiet time plus the write pulse itself.
  localparam int W_LIM = QUIET_CYC + 3;
  logic signed [UPOS_W-1:0] upos;
  logic no_enc, no_mv, zc, sc;
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Antecedents exclude same-cycle increments, which add on top, except a_zero_pos, which expects the step.
  assign upos = {position.step, position.ustep};
  assign no_enc = !enc_up && !enc_down;
  assign no_mv = !move_cmd.abs_move && !move_cmd.relative_move_cmd
                 && !move_cmd.shift_arm;
  assign zc = pos_cmd.set_zero && pos_valid;
  assign sc = pos_cmd.set_position_cmd && !pos_cmd.set_zero && pos_valid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Properties
  // ==========================================================================
  // Zeroing leaves only the step of its own cycle in the counter.
  a_zero_pos: assert property (
    zc |=> upos == ($past(step_pulse) ?
      ($past(step_dir) ? 40'sh1 : -40'sh1) : 40'sh0))
    else $error("step counter not cleared by zero");
  a_zero_enc: assert property (
    zc && no_enc |=> position.enc == 0)
    else $error("encoder not cleared with step counter");
  // Targets follow the logical position so physical end points hold.
  a_zero_tgt: assert property (
    zc && no_mv |=> target_pos == $past(target_pos) - $past(upos))
    else $error("target not shifted by zero");
  a_zero_sh: assert property (
    zc && no_mv |=> shift_dest == $past(shift_dest) - $past(upos))
    else $error("shift destination not kept by zero");
  // Set position loads the value and honours the encoder ignore flag.
  a_set_pos: assert property (
    sc && !pos_cmd.ign_pos && !step_pulse |=> upos == $past(pos_cmd.pos))
    else $error("set position value not loaded");
  a_ign_enc: assert property (
    sc && pos_cmd.ign_enc && no_enc |=> $stable(position.enc))
    else $error("ignored encoder changed");
  a_set_tgt: assert property (
    sc && !pos_cmd.ign_pos && no_mv |=> target_pos == $past(target_pos)
      - ($past(upos) - $past(pos_cmd.pos)))
    else $error("target not kept physical by set position");
  a_step: assert property (
    step_pulse && pos_valid && !pos_cmd.set_zero
      && !pos_cmd.set_position_cmd |=> upos == $past(upos)
      + ($past(step_dir) ? 40'sh1 : -40'sh1))
    else $error("step increment lost");
  // Restore and save of the record.
  a_restore: assert property (
    $past(nv_rd_req) && nv_rd_valid |=> pos_valid
      && position == $past(nv_rd_data.pos)
      && calib_needed == $past(nv_rd_data.moving))
    else $error("record not restored");
  a_save: assert property (
    $fell(motion_busy) && pos_valid |-> ##[1:W_LIM] nv_wr_en)
    else $error("no save after stop");
  a_save_rec: assert property (
    nv_wr_en |-> nv_wr_data.pos == $past(position)
      && nv_wr_data.moving == $past(motion_busy))
    else $error("saved record differs from position");
endmodule
bind pcad_position_counter pcad_position_counter_chk #(.QUIET_CYC(QUIET_CYC))
  u_chk (.clk(clk), .rstn(rstn), .step_pulse(step_pulse),
  .step_dir(step_dir), .enc_up(enc_up), .enc_down(enc_down),
  .motion_busy(motion_busy), .nv_rd_valid(nv_rd_valid),
  .calib_needed(calib_needed), .pos_valid(pos_valid),
  .nv_rd_req(nv_rd_req), .nv_wr_en(nv_wr_en), .pos_cmd(pos_cmd),
  .move_cmd(move_cmd), .nv_rd_data(nv_rd_data), .nv_wr_data(nv_wr_data),
  .position(position), .target_pos(target_pos), .shift_dest(shift_dest));

// >>> tb_top.sv
// Self-checking bench for the position counter with a store model.
// Assumes small save counts so the whole run stays short.
`timescale 1ns/10ps
module tb_top;
  import pcad_pkg::*;
  localparam int QC = 20;
  logic clk = 0, rstn = 0, step_pulse = 0, step_dir = 0;
  logic enc_up = 0, enc_down = 0, motion_busy = 0;
  pcad_pos_cmd_t pc = '0;
  pcad_move_cmd_t mc = '0;
  pcad_nv_rec_t rd_d, wr_d, rec;
  pcad_pos_t position;
  logic signed [39:0] tgt, sh, upos, e_pos, e_tgt, e_sh;
  logic signed [31:0] e_enc;
  logic rd_v, rd_r, wr_en, calib, pvalid, wr_mov;
  int n_fail = 0, n_tests = 0, cyc_n = 0, i;
  assign upos = {position.step, position.ustep};
  // ==========================================================================
  // Instances and clock
  // ==========================================================================
  always #50 clk = ~clk;
  pcad_position_counter #(.QUIET_CYC(QC), .PER_CYC(50)) dut (.clk(clk),
    .rstn(rstn), .step_pulse(step_pulse), .step_dir(step_dir),
    .enc_up(enc_up), .enc_down(enc_down), .motion_busy(motion_busy),
    .pos_cmd(pc), .move_cmd(mc), .nv_rd_valid(rd_v), .nv_rd_data(rd_d),
    .position(position), .target_pos(tgt), .shift_dest(sh),
    .calib_needed(calib), .pos_valid(pvalid), .nv_rd_req(rd_r),
    .nv_wr_en(wr_en), .nv_wr_data(wr_d));
  pcad_nv_model #(.INIT({1'b1, 32'sh5, 8'h03, -32'sh7})) u_nv (.clk(clk),
    .wr_data(wr_d), .rd_req(rd_r), .wr_en(wr_en), .rd_valid(rd_v),
    .rec(rec), .wr_moving(wr_mov), .rd_data(rd_d));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic st();
    chk("pos", e_pos, upos);
    chk("enc", e_enc, position.enc);
    chk("target", e_tgt, tgt);
    chk("shift", e_sh, sh);
  endtask
  task automatic pcmd(logic ip, logic ie, logic [39:0] p, logic [31:0] e);
    pc = '{1'b0, 1'b1, ip, ie, p, e};
    cyc();
    pc = '0;
    cyc();
  endtask
  task automatic mv(logic a, logic r, logic s, logic [39:0] v);
    mc = '{a, r, s, v};
    cyc();
    mc = '0;
    cyc();
  endtask
  task automatic results();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_restore(logic [39:0] p, logic [31:0] e, logic c);
    rstn = 0;
    repeat (3) cyc();
    rstn = 1;
    chk("valid", 0, pvalid);
    cyc();
    chk("read req", 1, rd_r);
    for (i = 0; i < 20 && pvalid !== 1'b1; i++) cyc();
    chk("valid", 1, pvalid);
    {e_pos, e_tgt, e_sh, e_enc} = {p, p, p, e};
    st();
    chk("calib", c, calib);
    $display("test restore done");
  endtask
  task automatic t_setpos();
    mv(1, 0, 0, 40'sd1000);
    pcmd(0, 0, 40'sd200, 32'sd55);
    e_tgt = 1000 - (e_pos - 200);
    e_sh = e_sh - (e_pos - 200);
    {e_pos, e_enc} = {40'sd200, 32'sd55};
    st();
    chk("calib", 0, calib);
    pcmd(1, 0, 40'sd999, 32'sd9);
    e_enc = 9;
    st();
    pcmd(0, 1, 40'sd300, 32'sd77);
    e_tgt = e_tgt + 100;
    e_sh = e_sh + 100;
    e_pos = 300;
    st();
    $display("test set position done");
  endtask
  task automatic t_zero();
    mv(1, 0, 0, 40'sd1000);
    mv(0, 0, 1, 40'sd50);
    {e_tgt, e_sh} = {40'sd1000, e_pos + 40'sd50};
    motion_busy = 1;
    for (i = 0; i < 3; i++) begin
      {step_pulse, step_dir, enc_up, enc_down} = {2'b11, i < 2, i == 2};
      cyc();
    end
    {enc_up, enc_down} = 2'b00;
    e_pos = e_pos + 3;
    e_enc = e_enc + 1;
    st();
    pc.set_zero = 1;
    cyc();
    pc = '0;
    step_pulse = 0;
    {e_tgt, e_sh} = {e_tgt - e_pos, e_sh - e_pos};
    {e_pos, e_enc} = {40'sd1, 32'sd0};
    st();
    mv(0, 1, 0, 40'sd10);
    e_tgt = e_tgt + 10;
    chk("target", e_tgt, tgt);
    $display("test zero done");
  endtask
  task automatic t_save();
    repeat (60) cyc();
    chk("moving save", 1, wr_mov);
    motion_busy = 0;
    for (i = 0; i < QC + 10 && wr_en !== 1'b1; i++) cyc();
    chk("save seen", 1, wr_en);
    cyc();
    chk("saved pos", e_pos, {rec.pos.step, rec.pos.ustep});
    chk("saved enc", e_enc, rec.pos.enc);
    chk("saved moving", 0, rec.moving);
    $display("test save done");
  endtask
  // ==========================================================================
  // Main sequence and timeout
  // ==========================================================================
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    t_restore(40'sd1283, -32'sd7, 1'b1);
    t_setpos();
    t_zero();
    t_save();
    t_restore(e_pos, e_enc, 1'b0);
    results();
  end
endmodule
